// ### hdl/plc_frame_and_channel_ctrl.sv
// power line frame builder, parser and channel control with wishbone slave
`timescale 1ns/10ps
`include "plc_map.svh"
module plc_frame_and_channel_ctrl #(
   parameter int          DEPTH      = 32,
   parameter logic [15:0] PSK_UW     = 16'h9af3,
   parameter logic [15:0] CRC16_POLY = 16'h1021,
   parameter logic [15:0] CRC16_INIT = 16'hffff,
   parameter logic [7:0]  CRC8_POLY  = 8'h07,
   parameter logic [7:0]  CRC8_INIT  = 8'h00
)(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [5:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_we_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        line_tx_ready,
   output logic      [7:0]  line_tx_byte,
   output logic             line_tx_valid,
   output logic             line_tx_high,
   output logic             line_tx_fsk,
   input  wire logic [7:0]  rx_hi_byte,
   input  wire logic        rx_hi_valid,
   input  wire logic [7:0]  rx_lo_byte,
   input  wire logic        rx_lo_valid,
   output logic      [1:0]  fsk_baud_sel,
   output logic             fsk_dev_half,
   output logic             rx_dual,
   output logic             rx_hi_fsk,
   output logic             rx_lo_fsk,
   output logic             rx_frame_ready
);
   localparam int IW = $clog2(DEPTH);

   logic [31:0]  ctrl_r, ctrl_nxt, uw_r, uw_nxt, dat_r, dat_nxt;
   logic [127:0] key_r, key_nxt;
   logic         ack_r, ack_nxt;
   plc_pkg::tx_state_e t_state_r, t_state_nxt;
   plc_pkg::rx_state_e r_state_r, r_state_nxt;
   logic [7:0]   t_cnt_r, t_cnt_nxt, t_len_r, t_len_nxt;
   logic [7:0]   pay_r, pay_nxt, tb_r, tb_nxt;
   logic         pay_v_r, pay_v_nxt, tv_r, tv_nxt;
   logic [15:0]  crc_t_r, crc_t_nxt, crc_r_r, crc_r_nxt;
   logic [15:0]  rcv_r, rcv_nxt;
   logic [7:0]   r_cnt_r, r_cnt_nxt, r_len_r, r_len_nxt;
   logic [7:0]   plen_r, plen_nxt, len_r, len_nxt, rd_r, rd_nxt;
   logic [31:0]  sh_hi_r, sh_hi_nxt, sh_lo_r, sh_lo_nxt;
   logic         lock_hi_r, lock_hi_nxt, rdy_r, rdy_nxt, bad_r, bad_nxt;
   logic [2:0]   mode_r, mode_nxt;
   logic         fsk_o_r, fsk_o_nxt;
   logic [7:0]   rbuf_r [DEPTH];
   logic [7:0]   rbuf_nxt [DEPTH];

   logic        crc16, lsbf, cov, fsk_t, req, go;
   logic [7:0]  crcb, rb, enc, cb;
   logic [2:0]  pre_n, uwn;
   logic [3:0]  widx;
   logic [31:0] m, uw_w;
   logic        rv;

   // serial crc, msb first per byte; width picked per frame
   function automatic logic [15:0] crc_upd(input logic [15:0] c,
                                           input logic [7:0]  d,
                                           input logic        w16);
      logic [15:0] r;
      logic        fb;
      r = c;
      for (int i = 7; i >= 0; i--)
      begin
         if (w16)
         begin
            fb = r[15] ^ d[i];
            r  = {r[14:0], 1'b0} ^ (fb ? CRC16_POLY : 16'h0000);
         end
         else
         begin
            fb = r[7] ^ d[i];
            r  = {8'h00, r[6:0], 1'b0} ^ (fb ? {8'h00, CRC8_POLY} : 16'h0000);
         end
      end
      return r;
   endfunction

   // compare the newest bytes of a channel against its start marker
   function automatic logic uw_hit(input logic [31:0] s, input logic f,
                                   input logic [2:0] n, input logic [31:0] w);
      logic [31:0] k;
      logic [2:0]  q;
      q = f ? n : 3'h2;
      case (q)
         3'h1:    k = 32'h000000ff;
         3'h2:    k = 32'h0000ffff;
         3'h3:    k = 32'h00ffffff;
         default: k = 32'hffffffff;
      endcase
      return ((s & k) == ((f ? w : {16'h0000, PSK_UW}) & k));
   endfunction

   assign crc16 = ctrl_r[`CTRL_CRC16];
   assign lsbf  = ctrl_r[`CTRL_LSBF];
   assign cov   = ctrl_r[`CTRL_COVLEN];
   assign crcb  = crc16 ? 8'h02 : 8'h01;
   assign uwn   = {1'b0, ctrl_r[`CTRL_UWN_LSB +: 2]} + 3'h1;
   assign fsk_t = ctrl_r[`CTRL_TXHI] ? ctrl_r[`CTRL_HIFSK]
                                     : ctrl_r[`CTRL_LOFSK];
   assign widx  = wb_adr_i[5:2];
   assign m     = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                   {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign uw_w  = fsk_t ? uw_r : {16'h0000, PSK_UW};
   assign rb    = lock_hi_r ? rx_hi_byte : rx_lo_byte;
   assign rv    = lock_hi_r ? rx_hi_valid : rx_lo_valid;
   assign enc   = ctrl_r[`CTRL_CIPH]
                ? pay_r ^ key_r[{t_cnt_r[3:0], 3'b000} +: 8] : pay_r;

   always_comb
   begin
      pre_n = ctrl_r[`CTRL_PRE_LSB +: 3];
      if (pre_n < `PRE_MIN)
         pre_n = `PRE_MIN;
      if (pre_n > `PRE_MAX)
         pre_n = `PRE_MAX;
      if (crc16 && (lsbf ? (t_cnt_r != 8'h00) : (t_cnt_r == 8'h00)))
         cb = crc_t_r[15:8];
      else
         cb = crc_t_r[7:0];
   end

   always_comb
   begin
      ctrl_nxt = ctrl_r;   uw_nxt = uw_r;       key_nxt = key_r;
      ack_nxt = 1'b0;      dat_nxt = 32'h0;
      t_state_nxt = t_state_r; t_cnt_nxt = t_cnt_r; t_len_nxt = t_len_r;
      pay_nxt = pay_r;     pay_v_nxt = pay_v_r;
      tb_nxt = tb_r;       tv_nxt = 1'b0;       crc_t_nxt = crc_t_r;
      r_state_nxt = r_state_r; r_cnt_nxt = r_cnt_r; r_len_nxt = r_len_r;
      crc_r_nxt = crc_r_r; rcv_nxt = rcv_r;     plen_nxt = plen_r;
      len_nxt = len_r;     rd_nxt = rd_r;       mode_nxt = mode_r;
      sh_hi_nxt = sh_hi_r; sh_lo_nxt = sh_lo_r; lock_hi_nxt = lock_hi_r;
      rdy_nxt = rdy_r;     bad_nxt = bad_r;
      rbuf_nxt = rbuf_r;

      // ====================================================
      // wishbone slave; a data write stalls while a byte waits
      req = wb_cyc_i & wb_stb_i & ~ack_r;
      go  = req & ~(wb_we_i & (widx == `REG_TXDATA) & pay_v_r);
      ack_nxt = go;
      if (go && wb_we_i)
      begin
         case (widx)
            `REG_CTRL:   ctrl_nxt = (ctrl_r & ~m) | (wb_dat_i & m);
            `REG_UW:     uw_nxt = (uw_r & ~m) | (wb_dat_i & m);
            `REG_STATUS:
               if (wb_sel_i[0] && wb_dat_i[0])
                  rdy_nxt = 1'b0;
            `REG_TXLEN:
               if (wb_sel_i[0] && t_state_r == plc_pkg::t_idle)
               begin
                  t_len_nxt   = wb_dat_i[7:0];
                  t_cnt_nxt   = 8'h00;
                  t_state_nxt = plc_pkg::t_pre;
               end
            `REG_TXDATA:
               if (wb_sel_i[0])
               begin
                  pay_nxt   = wb_dat_i[7:0];
                  pay_v_nxt = 1'b1;
               end
            `REG_KEY0, 4'h7, 4'h8, `REG_KEY3:
               key_nxt[{widx[1:0] - 2'h2, 5'b00000} +: 32] =
                  (key_r[{widx[1:0] - 2'h2, 5'b00000} +: 32] & ~m)
                  | (wb_dat_i & m);
            default: ;
         endcase
      end
      else if (go)
      begin
         case (widx)
            `REG_CTRL:   dat_nxt = ctrl_r;
            `REG_UW:     dat_nxt = uw_r;
            `REG_STATUS: dat_nxt = {13'h0, mode_r, len_r, 3'h0,
                                    r_state_r != plc_pkg::r_hunt,
                                    t_state_r != plc_pkg::t_idle,
                                    lock_hi_r, bad_r, rdy_r};
            `REG_TXLEN:  dat_nxt = {24'h0, t_len_r};
            `REG_RXDATA:
            begin
               dat_nxt = {24'h0, rbuf_r[rd_r[IW-1:0]]};
               if (rd_r < len_r)
                  rd_nxt = rd_r + 8'h01;
            end
            `REG_KEY0, 4'h7, 4'h8, `REG_KEY3:
               dat_nxt = key_r[{widx[1:0] - 2'h2, 5'b00000} +: 32];
            default:     dat_nxt = 32'h0;
         endcase
      end

      // ====================================================
      // transmit framer, at most one byte per ready cycle on one channel
      if (line_tx_ready && t_state_r != plc_pkg::t_idle)
      begin
         tv_nxt = 1'b1;
         case (t_state_r)
            plc_pkg::t_pre:
            begin
               tb_nxt    = `PRE_BYTE;
               t_cnt_nxt = t_cnt_r + 8'h01;
               if (t_cnt_r == {5'h00, pre_n - 3'h1})
               begin
                  t_cnt_nxt   = 8'h00;
                  t_state_nxt = plc_pkg::t_uw;
               end
            end
            plc_pkg::t_uw:
            begin
               tb_nxt = 8'((uw_w >> {(fsk_t ? uwn : 3'h2) - 3'h1
                                     - t_cnt_r[2:0], 3'b000}));
               t_cnt_nxt = t_cnt_r + 8'h01;
               if (t_cnt_r[2:0] == (fsk_t ? uwn : 3'h2) - 3'h1)
                  t_state_nxt = fsk_t ? plc_pkg::t_plen : plc_pkg::t_mode;
            end
            plc_pkg::t_mode:
            begin
               tb_nxt      = {5'h00, ctrl_r[`CTRL_MODE_LSB +: 3]};
               t_state_nxt = plc_pkg::t_plen;
            end
            plc_pkg::t_plen:
            begin
               tb_nxt      = t_len_r + crcb + 8'h01;
               crc_t_nxt   = crc16 ? CRC16_INIT : {8'h00, CRC8_INIT};
               t_state_nxt = plc_pkg::t_dlen;
            end
            plc_pkg::t_dlen:
            begin
               tb_nxt    = t_len_r + crcb;
               t_cnt_nxt = 8'h00;
               if (cov)
                  crc_t_nxt = crc_upd(crc_t_r, tb_nxt, crc16);
               t_state_nxt = (t_len_r == 8'h00) ? plc_pkg::t_crc
                                                : plc_pkg::t_pay;
            end
            plc_pkg::t_pay:
               if (pay_v_r)
               begin
                  tb_nxt    = enc;
                  pay_v_nxt = 1'b0;
                  crc_t_nxt = crc_upd(crc_t_r, enc, crc16);
                  t_cnt_nxt = t_cnt_r + 8'h01;
                  if (t_cnt_r == t_len_r - 8'h01)
                  begin
                     t_cnt_nxt   = 8'h00;
                     t_state_nxt = plc_pkg::t_crc;
                  end
               end
               else
                  tv_nxt = 1'b0;
            plc_pkg::t_crc:
            begin
               tb_nxt    = cb;
               t_cnt_nxt = t_cnt_r + 8'h01;
               if (t_cnt_r == crcb - 8'h01)
                  t_state_nxt = plc_pkg::t_idle;
            end
            default: t_state_nxt = plc_pkg::t_idle;
         endcase
      end

      // ====================================================
      // receive parser; hunting pauses while a frame awaits the host
      case (r_state_r)
         plc_pkg::r_hunt:
            if (!rdy_r)
            begin
               if (rx_hi_valid)
                  sh_hi_nxt = {sh_hi_r[23:0], rx_hi_byte};
               if (rx_lo_valid && ctrl_r[`CTRL_DUAL])
                  sh_lo_nxt = {sh_lo_r[23:0], rx_lo_byte};
               if (rx_hi_valid && uw_hit(sh_hi_nxt,
                                         ctrl_r[`CTRL_HIFSK], uwn, uw_r))
               begin
                  lock_hi_nxt = 1'b1;
                  r_state_nxt = ctrl_r[`CTRL_HIFSK] ? plc_pkg::r_plen
                                                    : plc_pkg::r_mode;
               end
               else if (rx_lo_valid && ctrl_r[`CTRL_DUAL] &&
                        uw_hit(sh_lo_nxt, ctrl_r[`CTRL_LOFSK], uwn, uw_r))
               begin
                  lock_hi_nxt = 1'b0;
                  r_state_nxt = ctrl_r[`CTRL_LOFSK] ? plc_pkg::r_plen
                                                    : plc_pkg::r_mode;
               end
               if (r_state_nxt != plc_pkg::r_hunt)
               begin
                  sh_hi_nxt = 32'h0;
                  sh_lo_nxt = 32'h0;
               end
            end
         plc_pkg::r_mode:
            if (rv)
            begin
               mode_nxt    = rb[2:0];
               r_state_nxt = plc_pkg::r_plen;
            end
         plc_pkg::r_plen:
            if (rv)
            begin
               plen_nxt    = rb;
               crc_r_nxt   = crc16 ? CRC16_INIT : {8'h00, CRC8_INIT};
               r_state_nxt = plc_pkg::r_dlen;
            end
         plc_pkg::r_dlen:
            if (rv)
            begin
               r_cnt_nxt = 8'h00;
               r_len_nxt = rb - crcb;
               if (cov)
                  crc_r_nxt = crc_upd(crc_r_r, rb, crc16);
               if (rb < crcb || {1'b0, rb} + 9'h001 != {1'b0, plen_r}
                   || {1'b0, rb - crcb} > 9'(DEPTH))
                  r_state_nxt = plc_pkg::r_hunt;
               else
                  r_state_nxt = (rb == crcb) ? plc_pkg::r_crc
                                             : plc_pkg::r_pay;
            end
         plc_pkg::r_pay:
            if (rv)
            begin
               rbuf_nxt[r_cnt_r[IW-1:0]] = ctrl_r[`CTRL_CIPH]
                  ? rb ^ key_r[{r_cnt_r[3:0], 3'b000} +: 8] : rb;
               crc_r_nxt = crc_upd(crc_r_r, rb, crc16);
               r_cnt_nxt = r_cnt_r + 8'h01;
               if (r_cnt_r == r_len_r - 8'h01)
               begin
                  r_cnt_nxt   = 8'h00;
                  r_state_nxt = plc_pkg::r_crc;
               end
            end
         plc_pkg::r_crc:
            if (rv)
            begin
               rcv_nxt   = (crc16 && lsbf) ? {rb, rcv_r[15:8]}
                                           : {rcv_r[7:0], rb};
               r_cnt_nxt = r_cnt_r + 8'h01;
               if (r_cnt_r == crcb - 8'h01)
               begin
                  r_state_nxt = plc_pkg::r_hunt;
                  bad_nxt = crc16 ? (rcv_nxt != crc_r_r)
                                  : (rcv_nxt[7:0] != crc_r_r[7:0]);
                  if (!bad_nxt || ctrl_r[`CTRL_SNIFF])
                  begin
                     rdy_nxt = 1'b1;
                     len_nxt = r_len_r;
                     rd_nxt  = 8'h00;
                  end
                  else
                     bad_nxt = bad_r;
               end
            end
         default: r_state_nxt = plc_pkg::r_hunt;
      endcase

      // family flag registered so the pin follows the control word
      fsk_o_nxt = ctrl_nxt[`CTRL_TXHI] ? ctrl_nxt[`CTRL_HIFSK]
                                       : ctrl_nxt[`CTRL_LOFSK];
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ctrl_r <= `CTRL_RST;  uw_r <= `UW_RST;  key_r <= 128'h0;
         ack_r <= 1'b0;        dat_r <= 32'h0;
         t_state_r <= plc_pkg::t_idle; t_cnt_r <= 8'h00; t_len_r <= 8'h00;
         pay_r <= 8'h00;       pay_v_r <= 1'b0;
         tb_r <= 8'h00;        tv_r <= 1'b0;     crc_t_r <= 16'h0000;
         r_state_r <= plc_pkg::r_hunt; r_cnt_r <= 8'h00; r_len_r <= 8'h00;
         crc_r_r <= 16'h0000;  rcv_r <= 16'h0000; plen_r <= 8'h00;
         len_r <= 8'h00;       rd_r <= 8'h00;    mode_r <= 3'h0;
         sh_hi_r <= 32'h0;     sh_lo_r <= 32'h0; lock_hi_r <= 1'b1;
         rdy_r <= 1'b0;        bad_r <= 1'b0;    fsk_o_r <= 1'b0;
         for (int i = 0; i < DEPTH; i++)
            rbuf_r[i] <= 8'h00;
      end
      else
      begin
         ctrl_r <= ctrl_nxt;   uw_r <= uw_nxt;   key_r <= key_nxt;
         ack_r <= ack_nxt;     dat_r <= dat_nxt;
         t_state_r <= t_state_nxt; t_cnt_r <= t_cnt_nxt; t_len_r <= t_len_nxt;
         pay_r <= pay_nxt;     pay_v_r <= pay_v_nxt;
         tb_r <= tb_nxt;       tv_r <= tv_nxt;   crc_t_r <= crc_t_nxt;
         r_state_r <= r_state_nxt; r_cnt_r <= r_cnt_nxt; r_len_r <= r_len_nxt;
         crc_r_r <= crc_r_nxt; rcv_r <= rcv_nxt; plen_r <= plen_nxt;
         len_r <= len_nxt;     rd_r <= rd_nxt;   mode_r <= mode_nxt;
         sh_hi_r <= sh_hi_nxt; sh_lo_r <= sh_lo_nxt; lock_hi_r <= lock_hi_nxt;
         rdy_r <= rdy_nxt;     bad_r <= bad_nxt; fsk_o_r <= fsk_o_nxt;
         rbuf_r <= rbuf_nxt;
      end
   end

   // the mixed fsk/psk rate cap is left to software
   assign wb_dat_o       = dat_r;
   assign wb_ack_o       = ack_r;
   assign line_tx_byte   = tb_r;
   assign line_tx_valid  = tv_r;
   assign line_tx_high   = ctrl_r[`CTRL_TXHI];
   assign line_tx_fsk    = fsk_o_r;
   assign fsk_baud_sel   = ctrl_r[`CTRL_BAUD_LSB +: 2];
   assign fsk_dev_half   = ctrl_r[`CTRL_DEV];
   assign rx_dual        = ctrl_r[`CTRL_DUAL];
   assign rx_hi_fsk      = ctrl_r[`CTRL_HIFSK];
   assign rx_lo_fsk      = ctrl_r[`CTRL_LOFSK];
   assign rx_frame_ready = rdy_r;
endmodule

// ### hdl/plc_map.svh
// register map, field positions and reset values of the frame controller
// Function
// - preamble of 0xaa bytes, two to five
// - programmable unique word marks fsk frame start; psk uses the fixed PSK_UW
// - payload opens with its own length byte
// - both ends need identical fsk settings
// - one fsk parameter set for tx and rx
// - transmit on exactly one chosen channel
// - single mode listens to high channel only
// - dual mode locks onto first valid channel
// - each receive channel is psk or fsk
// - link length counts payload plus crc
// - host picks crc width, order and coverage
// - transmit appends computed crc
// - receive delivers only frames with matching crc
// - sniffer also reports frames failing crc
// - payload ciphered with shared readable 128-bit key
// - fsk rate selectable 1200 to 9600 baud
`ifndef PLC_MAP_SVH
`define PLC_MAP_SVH

// word indices; byte address is four times the index
`define REG_CTRL    4'h0
`define REG_UW      4'h1
`define REG_STATUS  4'h2
`define REG_TXLEN   4'h3
`define REG_TXDATA  4'h4
`define REG_RXDATA  4'h5
`define REG_KEY0    4'h6
`define REG_KEY3    4'h9

// control fields
`define CTRL_PRE_LSB  0
`define CTRL_UWN_LSB  3
`define CTRL_BAUD_LSB 5
`define CTRL_DEV      7
`define CTRL_DUAL     8
`define CTRL_TXHI     9
`define CTRL_HIFSK    10
`define CTRL_LOFSK    11
`define CTRL_CRC16    12
`define CTRL_LSBF     13
`define CTRL_COVLEN   14
`define CTRL_SNIFF    15
`define CTRL_CIPH     16
`define CTRL_MODE_LSB 17

`define CTRL_RST      32'h0000020a
`define UW_RST        32'h00009b58
`define PRE_BYTE      8'haa
`define PRE_MIN       3'h2
`define PRE_MAX       3'h5

`endif

// ### hdl/plc_pkg.sv
// state types of the frame controller
package plc_pkg;
   typedef enum logic [2:0] {
      t_idle = 3'b000, t_pre = 3'b001, t_uw = 3'b010, t_mode = 3'b011,
      t_plen = 3'b100, t_dlen = 3'b101, t_pay = 3'b110, t_crc = 3'b111
   } tx_state_e;
   typedef enum logic [2:0] {
      r_hunt = 3'b000, r_mode = 3'b001, r_plen = 3'b010,
      r_dlen = 3'b011, r_pay = 3'b100, r_crc = 3'b101
   } rx_state_e;
endpackage

// ### tb/plc_chk.sv
// port-level checks of the frame controller
`timescale 1ns/10ps
module plc_chk (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic [5:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic        wb_we_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        line_tx_valid,
   input wire logic        line_tx_high,
   input wire logic        line_tx_fsk,
   input wire logic        rx_hi_valid,
   input wire logic        rx_lo_valid,
   input wire logic [1:0]  fsk_baud_sel,
   input wire logic        rx_dual,
   input wire logic        rx_hi_fsk,
   input wire logic        rx_lo_fsk,
   input wire logic        rx_frame_ready
);
   // ====================
   // assertions
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
   property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("data not idle");
   property p_hi_stable; line_tx_valid |-> $stable(line_tx_high); endproperty
   a_hi_stable: assert property (p_hi_stable)
      else $error("channel moved in frame");
   property p_fsk_family;
      line_tx_fsk == (line_tx_high ? rx_hi_fsk : rx_lo_fsk);
   endproperty
   a_fsk_family: assert property (p_fsk_family)
      else $error("tx family wrong");
   property p_rdy_cause;
      $rose(rx_frame_ready) |-> $past(rx_hi_valid || rx_lo_valid);
   endproperty
   a_rdy_cause: assert property (p_rdy_cause)
      else $error("ready without byte");
   property p_single_hi;
      $rose(rx_frame_ready) && !rx_dual |-> $past(rx_hi_valid);
   endproperty
   a_single_hi: assert property (p_single_hi)
      else $error("low channel heard");
   property p_rdy_clear;
      $fell(rx_frame_ready) |-> wb_ack_o && wb_we_i && wb_dat_i[0]
         && wb_adr_i[5:2] == 4'h2;
   endproperty
   a_rdy_clear: assert property (p_rdy_clear) else $error("ready lost");
   property p_cfg_write;
      $changed({rx_dual, fsk_baud_sel}) |-> wb_ack_o && wb_we_i
         && wb_adr_i[5:2] == 4'h0;
   endproperty
   a_cfg_write: assert property (p_cfg_write)
      else $error("config moved alone");
endmodule

// ### tb/plc_line_model.sv
// line-side partner: modulator sink and remote modem source
`timescale 1ns/10ps
module plc_line_model (
   input  wire logic       clk,
   input  wire logic [7:0] line_tx_byte,
   input  wire logic       line_tx_valid,
   output logic            line_tx_ready,
   output logic      [7:0] rx_hi_byte,
   output logic            rx_hi_valid,
   output logic      [7:0] rx_lo_byte,
   output logic            rx_lo_valid
);
   logic [7:0] cap[$];
   logic [7:0] dat = 8'h0;
   logic [7:0] noise = 8'h0;
   // ====================
   // sink stalls at random so the framer must hold its byte
   initial
   begin
      line_tx_ready = 1'b0;
      rx_hi_valid = 1'b0;
      rx_lo_valid = 1'b0;
   end
   always @(posedge clk)
   begin
      line_tx_ready <= $urandom % 4 != 0;
      noise <= 8'($urandom);
      if (line_tx_valid === 1'b1) cap.push_back(line_tx_byte);
   end
   // a quiet channel shows noise, never the last byte
   assign rx_hi_byte = rx_hi_valid ? dat : noise;
   assign rx_lo_byte = rx_lo_valid ? dat : noise;
   // replay with identical settings; bad flips the last crc bit
   task automatic send(input logic hi, input logic bad);
      foreach (cap[i])
      begin
         @(posedge clk);
         dat <= cap[i] ^ {7'h0, bad && i == cap.size() - 1};
         rx_hi_valid <= hi;
         rx_lo_valid <= !hi;
         @(posedge clk);
         rx_hi_valid <= 1'b0;
         rx_lo_valid <= 1'b0;
      end
   endtask
endmodule

// ### tb/tb.sv
// self-checking bench: framing, crc, channels and registers
`timescale 1ns/10ps
`include "plc_map.svh"
module tb;
   localparam logic [15:0] PSK_W = 16'h9af3;
   logic         clk, sys_rst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
   logic [5:0]   wb_adr_i;
   logic [31:0]  wb_dat_i, wb_dat_o, uw;
   logic [3:0]   wb_sel_i;
   logic [7:0]   line_tx_byte, rx_hi_byte, rx_lo_byte;
   logic         line_tx_ready, line_tx_valid, line_tx_high, line_tx_fsk;
   logic         rx_hi_valid, rx_lo_valid, fsk_dev_half, rx_dual;
   logic         rx_hi_fsk, rx_lo_fsk, rx_frame_ready;
   logic [1:0]   fsk_baud_sel;
   logic [127:0] key;
   logic [7:0]   exp_tx[$], pl[$];
   logic [63:0]  exp_rd[$];
   int           n_fail = 0;
   int           total_checks = 0;
   plc_frame_and_channel_ctrl #(.PSK_UW(PSK_W)) dut_u (.*);
   plc_line_model lm (.*);
   // ====================
   // tasks
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, e, m);
      total_checks++;
      if ((s & m) !== (e & m))
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen %h want %h", $time, s, e);
      end
   endtask
   // reads queue d under mask m; writes send d
   task automatic bus(input logic [5:0] a, input logic w,
                      input logic [31:0] d, m);
      int i;
      if (!w) exp_rd.push_back({m, d});
      @(posedge clk);
      wb_adr_i <= a;
      wb_we_i <= w;
      wb_dat_i <= w ? d : 32'h0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      i = 0;
      do
      begin
         @(posedge clk);
         i++;
      end
      while (wb_ack_o !== 1'b1 && i < 500);
      if (wb_ack_o !== 1'b1) n_fail++;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   function automatic logic [15:0] crcu(logic [15:0] r, logic [7:0] d,
                                        logic w);
      for (int k = 7; k >= 0; k--)
         if (w) r = {r[14:0], 1'b0} ^ ((r[15] ^ d[k]) ? 16'h1021 : 16'h0);
         else r[7:0] = {r[6:0], 1'b0} ^ ((r[7] ^ d[k]) ? 8'h07 : 8'h0);
      return r;
   endfunction
   task automatic frame(input logic [31:0] c, input int n);
      logic [15:0] r;
      logic [7:0]  x;
      int          i, k;
      k = c[2:0] < 2 ? 2 : (c[2:0] > 5 ? 5 : int'(c[2:0]));
      r = c[12] ? 16'hffff : 16'h0;
      pl.delete();
      lm.cap.delete();
      bus(6'h00, 1, c, 0);
      chk({line_tx_high, line_tx_fsk},
          {c[9], c[9] ? c[10] : c[11]}, 3);
      repeat (k) exp_tx.push_back(`PRE_BYTE);
      if (c[9] ? c[10] : c[11])
         for (i = int'(c[4:3]); i >= 0; i--) exp_tx.push_back(uw[8*i+:8]);
      else
      begin
         exp_tx.push_back(PSK_W[15:8]);
         exp_tx.push_back(PSK_W[7:0]);
         exp_tx.push_back({5'h0, c[19:17]});
      end
      k = n + (c[12] ? 2 : 1);
      exp_tx.push_back(8'(k + 1));
      exp_tx.push_back(8'(k));
      if (c[14]) r = crcu(r, 8'(k), c[12]);
      for (i = 0; i < n; i++)
      begin
         x = 8'($urandom);
         pl.push_back(x);
         if (c[16]) x = x ^ key[8*(i%16)+:8];
         exp_tx.push_back(x);
         r = crcu(r, x, c[12]);
      end
      if (c[12]) exp_tx.push_back(c[13] ? r[7:0] : r[15:8]);
      exp_tx.push_back(c[12] && c[13] ? r[15:8] : r[7:0]);
      bus(6'h0c, 1, n, 0);
      bus(6'h0c, 0, n, 32'hff);
      foreach (pl[j]) bus(6'h10, 1, {24'h0, pl[j]}, 0);
      repeat (3000) if (exp_tx.size() > 0) @(posedge clk);
      if (exp_tx.size() > 0) n_fail++;
      repeat (2) @(posedge clk);
   endtask
   task automatic rx(input logic hi, bad, e, input logic [31:0] st);
      lm.send(hi, bad);
      repeat (4) if (rx_frame_ready !== 1'b1) @(posedge clk);
      chk({31'h0, rx_frame_ready}, {31'h0, e}, 1);
      if (e)
      begin
         bus(6'h08, 0, st, 32'h0000ff07);
         foreach (pl[j]) bus(6'h14, 0, {24'h0, pl[j]}, 32'hff);
         bus(6'h08, 1, 1, 0);
      end
   endtask
   // ====================
   // monitor
   always @(posedge clk)
   begin
      logic [63:0] q;
      logic [7:0]  t;
      if (!sys_rst && wb_ack_o === 1'b1 && !wb_we_i)
      begin
         q = exp_rd.size() > 0 ? exp_rd.pop_front() : {32'hffffffff, 32'hx};
         chk(wb_dat_o, q[31:0], q[63:32]);
      end
      if (line_tx_valid === 1'b1)
      begin
         t = exp_tx.size() > 0 ? exp_tx.pop_front() : 8'hxx;
         chk({24'h0, line_tx_byte}, {24'h0, t}, 32'hff);
      end
   end
   // ====================
   // sequence
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      conclude;
   end
   initial
   begin
      {sys_rst, wb_adr_i, wb_dat_i, wb_we_i, wb_cyc_i, wb_stb_i} = '0;
      sys_rst = 1'b1;
      wb_sel_i = 4'hf;
      uw = `UW_RST;
      void'($urandom(22081));
      repeat (16) @(posedge clk);
      chk({line_tx_high, rx_dual, rx_frame_ready}, 4, 7);
      sys_rst <= 1'b0;
      bus(6'h00, 0, `CTRL_RST, '1);
      bus(6'h04, 0, `UW_RST, '1);
      bus(6'h28, 1, 32'h5a5a5a5a, 0);
      bus(6'h28, 0, 0, '1);
      for (int i = 0; i < 4; i++)
      begin
         key[32*i+:32] = $urandom;
         bus(6'h18 + 6'(4 * i), 1, key[32*i+:32], 0);
         bus(6'h18 + 6'(4 * i), 0, key[32*i+:32], '1);
      end
      for (int b = 0; b < 4; b++)
      begin
         bus(6'h00, 1, 32'(b * 32 + 128), 0);
         chk({fsk_dev_half, fsk_baud_sel}, 4 + b, 7);
      end
      frame(`CTRL_RST, 1);
      frame(32'h00067205, 3);
      rx(1, 0, 1, 32'h0305);
      uw = 32'hc3a55a3c;
      bus(6'h04, 1, uw, 0);
      frame(32'h0001063b, 5);
      rx(1, 0, 1, 32'h0505);
      frame(32'h00001000, 6);
      frame(`CTRL_RST, 4);
      rx(1, 0, 1, 32'h0405);
      rx(0, 0, 0, 0);
      bus(6'h00, 1, 32'h30a, 0);
      rx(0, 0, 1, 32'h0401);
      rx(1, 1, 0, 0);
      bus(6'h00, 1, 32'h830a, 0);
      rx(1, 1, 1, 32'h0407);
      conclude;
   end
endmodule
bind plc_frame_and_channel_ctrl plc_chk chk_u (.*);
